/* hdl/rlso_channel.sv */
// One limit comparator: picks X, relative X or Y and compares with the threshold.
// Assumes samples and threshold are two's complement of the same width.
`timescale 1ns/1ps
module rlso_channel
    import rlso_pkg::*;
#(
    parameter int DW = RLSO_DW
) (
    input logic [DW-1:0] meas_x,
    input logic [DW-1:0] meas_y,
    input logic [DW-1:0] x_ref,
    input rlso_cfg_type cfg,
    input logic gref_ok,
    input logic [DW-1:0] threshold,
    output logic exceeds
);

    logic [DW-1:0] x_rel;
    logic [DW-1:0] val;

    // Relative X wraps on overflow; ranges are expected to stay well inside
    assign x_rel = meas_x - x_ref;

    always_comb begin
        if (cfg.chan_y) begin
            val = meas_y;
        end else if (cfg.ref_trig && gref_ok) begin
            val = x_rel;
        end else begin
            val = meas_x;
        end
    end

    assign exceeds = $signed(val) > $signed(threshold);

endmodule

/* hdl/rlso_curve_store.sv */
// Per-program ring of the most recent recorded curve summaries.
// Assumes push is a one-cycle pulse; slot 0 reads the oldest kept curve.
`timescale 1ns/1ps
module rlso_curve_store
    import rlso_pkg::*;
#(
    parameter int RW = RLSO_RW,
    parameter int NPROG = RLSO_NPROG,
    parameter int DEPTH = RLSO_CURVE_DEPTH,
    parameter int PW = 2,
    parameter int SW = RLSO_SLOT_W
) (
    input logic clk,
    input logic rst_n,
    input logic push,
    input logic [PW-1:0] prog,
    input logic [RW-1:0] rec,
    input logic [SW-1:0] rd_slot,
    output logic [RW-1:0] rd_rec,
    output logic [SW-1:0] count
);

    logic [RW-1:0] mem_q [NPROG*DEPTH];
    logic [SW-1:0] ptr_q [NPROG];
    logic [SW-1:0] ptr_d [NPROG];
    logic [SW-1:0] cnt_q [NPROG];
    logic [SW-1:0] cnt_d [NPROG];
    int rd_idx;

    // ==========================================================
    // Ring pointers: the oldest entry is overwritten once full
    always_comb begin
        ptr_d = ptr_q;
        cnt_d = cnt_q;
        if (push) begin
            ptr_d[prog] = (ptr_q[prog] == SW'(DEPTH - 1)) ? '0 : ptr_q[prog] + 1'b1;
            if (cnt_q[prog] != SW'(DEPTH)) begin
                cnt_d[prog] = cnt_q[prog] + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int p = 0; p < NPROG; p++) begin
                ptr_q[p] <= '0;
                cnt_q[p] <= '0;
            end
        end else begin
            ptr_q <= ptr_d;
            cnt_q <= cnt_d;
        end
    end

    // Curve memory is not reset; the count guards reads of stale slots
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[int'(prog) * DEPTH + int'(ptr_q[prog])] <= rec;
        end
    end

    // ==========================================================
    // Read by age within the selected program
    always_comb begin
        rd_idx = (int'(ptr_q[prog]) + DEPTH - int'(cnt_q[prog]) + int'(rd_slot)) % DEPTH;
        rd_rec = '0;
        if (rd_slot < cnt_q[prog]) begin
            rd_rec = mem_q[int'(prog) * DEPTH + rd_idx];
        end
    end

    assign count = cnt_q[prog];

endmodule

/* hdl/rlso_pkg.sv */
// Constants, register map and types shared by the limit switch output block.
// Assumes a single sample clock and a synchronous active-low reset.
package rlso_pkg;

    // ==========================================================
    // Sizes
    localparam int RLSO_NOUT = 6;
    localparam int RLSO_DW = 16;
    localparam int RLSO_RW = 32;
    localparam int RLSO_AW = 8;
    localparam int RLSO_NPLC = 8;
    localparam int RLSO_NPROG = 4;
    localparam int RLSO_CURVE_DEPTH = 10;
    localparam int RLSO_SLOT_W = 4;
    localparam int RLSO_MAP_W = 3;
    localparam int RLSO_NEV = 8;
    localparam int RLSO_EV_CURVE = 6;
    localparam int RLSO_EV_AUTO = 7;

    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_GREF = 8'h04;
    localparam logic [7:0] ADDR_PROG = 8'h08;
    localparam logic [7:0] ADDR_MAP = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    localparam logic [7:0] ADDR_LEVEL = 8'h18;
    localparam logic [7:0] ADDR_SLOT = 8'h1C;
    localparam logic [7:0] ADDR_CURVE = 8'h20;
    localparam logic [7:0] ADDR_CCOUNT = 8'h24;
    // Per output: config at base + 8*n, threshold at base + 8*n + 4
    localparam logic [7:0] ADDR_CFG_BASE = 8'h40;

    // ==========================================================
    // Reset values
    localparam logic [11:0] RST_MAP = 12'hB1A;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        RLSO_IDLE = 2'b00,
        RLSO_MEASURE = 2'b01,
        RLSO_GRAPH = 2'b10
    } rlso_mode_type;

    typedef enum logic [1:0] {
        RLSO_GREF_NONE = 2'b00,
        RLSO_GREF_YOVER = 2'b01,
        RLSO_GREF_YUNDER = 2'b10
    } rlso_gref_type;

    typedef struct packed {
        logic ref_trig;
        logic pol_high;
        logic chan_y;
    } rlso_cfg_type;

endpackage

/* hdl/rlso_top.sv */
// Six real-time limit switch outputs with register port, PLC routing,
// curve history for graphical test operation and one level interrupt.
// Assumes measurement inputs are synchronous to clk and held between samples.
//
// Overview of operation
// - Each output picks the X or the Y channel independently.
// - Each output holds its own programmable threshold.
// - Each output has a polarity bit choosing active high or low.
// - Absolute X referencing compares threshold with raw X.
// - Trigger referencing compares threshold with X minus X at Y trigger.
// - Trigger referencing accepted only when global reference is a Y trigger.
// - Outputs one and two fixed on PLC; three to six routed by map.
// - Graphical test keeps ten newest curves per program, dropping the oldest.
// - Auto-mode input in graphical test returns the device to measuring.
// - Graphical test keeps control inputs and switch outputs working.
// - Envelope generation reads the stored curves of the current program.
// - Outputs drive only in measuring or graphical test, else inactive.
`timescale 1ns/1ps
module rlso_top
    import rlso_pkg::*;
#(
    parameter int DW = RLSO_DW,
    parameter int NPROG = RLSO_NPROG,
    parameter int NPLC = RLSO_NPLC
) (
    input logic clk,
    input logic rst_n,
    input logic [DW-1:0] meas_x,
    input logic [DW-1:0] meas_y,
    input logic sample_valid,
    input logic y_trigger,
    input logic curve_end,
    input logic in_auto,
    input logic [RLSO_AW-1:0] reg_addr,
    input logic [RLSO_RW-1:0] reg_wdata,
    input logic reg_we,
    input logic reg_re,
    output logic [RLSO_RW-1:0] reg_rdata,
    output logic [RLSO_NOUT-1:0] limit_switch_outputs,
    output logic [NPLC-1:0] plc_out,
    output logic [1:0] op_mode,
    output logic irq
);

    localparam int PW = $clog2(NPROG);

    rlso_mode_type mode_q, mode_d;
    logic [1:0] gref_q, gref_d;
    logic [PW-1:0] prog_q, prog_d;
    logic [11:0] map_q, map_d;
    logic [RLSO_NEV-1:0] status_q, status_d, mask_q, mask_d, ev_set;
    rlso_cfg_type cfg_q [RLSO_NOUT];
    rlso_cfg_type cfg_d [RLSO_NOUT];
    logic [DW-1:0] thr_q [RLSO_NOUT];
    logic [DW-1:0] thr_d [RLSO_NOUT];
    logic [RLSO_SLOT_W-1:0] slot_q, slot_d;
    logic [RLSO_RW-1:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic [DW-1:0] xref_q, xref_d, pk_x_q, pk_x_d, pk_y_q, pk_y_d;
    logic [RLSO_NOUT-1:0] act_q, act_d, sw_q, sw_d, exc;
    logic [NPLC-1:0] plc_q, plc_d;
    logic gref_ok, active, graph, cfg_hit, thr_wr, curve_push, wr_prog;
    logic [2:0] cfg_idx;
    logic [RLSO_RW-1:0] curve_rec;
    logic [RLSO_SLOT_W-1:0] curve_cnt;
    int pos;

    assign gref_ok = (gref_q == RLSO_GREF_YOVER) || (gref_q == RLSO_GREF_YUNDER);
    assign active = (mode_q == RLSO_MEASURE) || (mode_q == RLSO_GRAPH);
    assign graph = (mode_q == RLSO_GRAPH);
    assign cfg_hit = (reg_addr[7:6] == ADDR_CFG_BASE[7:6]) && (reg_addr[1:0] == 2'b00)
                     && (int'(reg_addr[5:3]) < RLSO_NOUT);
    assign cfg_idx = reg_addr[5:3];
    assign thr_wr = reg_addr[2];
    assign wr_prog = reg_we && (reg_addr == ADDR_PROG);
    assign curve_push = graph && curve_end;

    // ==========================================================
    // Comparators, one per output
    genvar gi;
    generate
        for (gi = 0; gi < RLSO_NOUT; gi++) begin : g_chan
            rlso_channel #(.DW(DW)) u_chan (
                .meas_x(meas_x),
                .meas_y(meas_y),
                .x_ref(xref_q),
                .cfg(cfg_q[gi]),
                .gref_ok(gref_ok),
                .threshold(thr_q[gi]),
                .exceeds(exc[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Curve history; envelope generation reads it through the slot window
    rlso_curve_store #(.RW(RLSO_RW), .NPROG(NPROG), .DEPTH(RLSO_CURVE_DEPTH), .PW(PW),
                       .SW(RLSO_SLOT_W)) u_store (
        .clk(clk),
        .rst_n(rst_n),
        .push(curve_push),
        .prog(prog_q),
        .rec(RLSO_RW'({pk_y_q, pk_x_q})),
        .rd_slot(slot_q),
        .rd_rec(curve_rec),
        .count(curve_cnt)
    );

    // ==========================================================
    // Register file, mode and interrupt state
    always_comb begin
        mode_d = mode_q;
        gref_d = gref_q;
        prog_d = prog_q;
        map_d = map_q;
        mask_d = mask_q;
        slot_d = slot_q;
        cfg_d = cfg_q;
        thr_d = thr_q;
        status_d = status_q;
        if (reg_we) begin
            if (reg_addr == ADDR_MODE) begin
                if (reg_wdata[1:0] != 2'b11) begin
                    mode_d = rlso_mode_type'(reg_wdata[1:0]);
                end
            end else if (reg_addr == ADDR_GREF) begin
                gref_d = reg_wdata[1:0];
            end else if (reg_addr == ADDR_PROG) begin
                prog_d = reg_wdata[PW-1:0];
            end else if (reg_addr == ADDR_MAP) begin
                map_d = reg_wdata[11:0];
            end else if (reg_addr == ADDR_STATUS) begin
                status_d = status_q & ~reg_wdata[RLSO_NEV-1:0];
            end else if (reg_addr == ADDR_MASK) begin
                mask_d = reg_wdata[RLSO_NEV-1:0];
            end else if (reg_addr == ADDR_SLOT) begin
                slot_d = reg_wdata[RLSO_SLOT_W-1:0];
            end else if (cfg_hit && thr_wr) begin
                thr_d[cfg_idx] = reg_wdata[DW-1:0];
            end else if (cfg_hit) begin
                cfg_d[cfg_idx] = rlso_cfg_type'(reg_wdata[2:0]);
                cfg_d[cfg_idx].ref_trig = reg_wdata[2] && gref_ok;
            end
        end
        // Auto input wins over a software mode write in the same cycle
        if (graph && in_auto) begin
            mode_d = RLSO_MEASURE;
        end
        // Hardware set wins over a simultaneous write-one clear
        status_d = status_d | ev_set;
        irq_d = |(status_d & mask_d);
    end

    always_comb begin
        ev_set = '0;
        ev_set[RLSO_NOUT-1:0] = act_d & ~act_q;
        ev_set[RLSO_EV_CURVE] = curve_push;
        ev_set[RLSO_EV_AUTO] = graph && in_auto;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q <= RLSO_IDLE;
            gref_q <= RLSO_GREF_NONE;
            prog_q <= '0;
            map_q <= RST_MAP;
            status_q <= '0;
            mask_q <= '0;
            slot_q <= '0;
            irq_q <= 1'b0;
            for (int i = 0; i < RLSO_NOUT; i++) begin
                cfg_q[i] <= '0;
                thr_q[i] <= '0;
            end
        end else begin
            mode_q <= mode_d;
            gref_q <= gref_d;
            prog_q <= prog_d;
            map_q <= map_d;
            status_q <= status_d;
            mask_q <= mask_d;
            slot_q <= slot_d;
            irq_q <= irq_d;
            cfg_q <= cfg_d;
            thr_q <= thr_d;
        end
    end

    // ==========================================================
    // Output datapath, trigger capture and curve peaks
    always_comb begin
        xref_d = xref_q;
        if (active && y_trigger) begin
            xref_d = meas_x;
        end
        // Same comparison path in both modes keeps outputs live in test operation
        act_d = active ? exc : '0;
        for (int i = 0; i < RLSO_NOUT; i++) begin
            sw_d[i] = act_d[i] ~^ cfg_q[i].pol_high;
        end
        plc_d = '0;
        plc_d[0] = sw_d[0];
        plc_d[1] = sw_d[1];
        // Positions 0 and 1 stay reserved for the fixed outputs
        for (int k = 2; k < RLSO_NOUT; k++) begin
            pos = int'(map_q[(k-2)*RLSO_MAP_W +: RLSO_MAP_W]);
            if (pos >= 2 && pos < NPLC) begin
                plc_d[pos] = sw_d[k];
            end
        end
        pk_x_d = pk_x_q;
        pk_y_d = pk_y_q;
        if (curve_push) begin
            pk_x_d = {1'b1, {(DW-1){1'b0}}};
            pk_y_d = {1'b1, {(DW-1){1'b0}}};
        end else if (graph && sample_valid) begin
            if ($signed(meas_x) > $signed(pk_x_q)) begin
                pk_x_d = meas_x;
            end
            if ($signed(meas_y) > $signed(pk_y_q)) begin
                pk_y_d = meas_y;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            xref_q <= '0;
            act_q <= '0;
            sw_q <= '0;
            plc_q <= '0;
            pk_x_q <= '0;
            pk_y_q <= '0;
        end else begin
            xref_q <= xref_d;
            act_q <= act_d;
            sw_q <= sw_d;
            plc_q <= plc_d;
            pk_x_q <= pk_x_d;
            pk_y_q <= pk_y_d;
        end
    end

    // ==========================================================
    // Read data, valid only in the cycle after the strobe
    always_comb begin
        rdata_d = '0;
        if (reg_re) begin
            if (reg_addr == ADDR_MODE) begin
                rdata_d = RLSO_RW'(mode_q);
            end else if (reg_addr == ADDR_GREF) begin
                rdata_d = RLSO_RW'(gref_q);
            end else if (reg_addr == ADDR_PROG) begin
                rdata_d = RLSO_RW'(prog_q);
            end else if (reg_addr == ADDR_MAP) begin
                rdata_d = RLSO_RW'(map_q);
            end else if (reg_addr == ADDR_STATUS) begin
                rdata_d = RLSO_RW'(status_q);
            end else if (reg_addr == ADDR_MASK) begin
                rdata_d = RLSO_RW'(mask_q);
            end else if (reg_addr == ADDR_LEVEL) begin
                rdata_d = RLSO_RW'(act_q);
            end else if (reg_addr == ADDR_SLOT) begin
                rdata_d = RLSO_RW'(slot_q);
            end else if (reg_addr == ADDR_CURVE) begin
                rdata_d = curve_rec;
            end else if (reg_addr == ADDR_CCOUNT) begin
                rdata_d = RLSO_RW'(curve_cnt);
            end else if (cfg_hit && thr_wr) begin
                rdata_d = RLSO_RW'(thr_q[cfg_idx]);
            end else if (cfg_hit) begin
                rdata_d = RLSO_RW'(cfg_q[cfg_idx]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign limit_switch_outputs = sw_q;
    assign plc_out = plc_q;
    assign op_mode = mode_q;
    assign irq = irq_q;

    // ==========================================================
    // Checks
    property p_idle_quiet;
        @(posedge clk) disable iff (!rst_n)
        (mode_q == RLSO_IDLE) |=> (act_q == '0);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("output active outside working modes");

    property p_auto_exit;
        @(posedge clk) disable iff (!rst_n)
        (graph && in_auto) |=> (mode_q == RLSO_MEASURE) && status_q[RLSO_EV_AUTO];
    endproperty
    a_auto_exit: assert property (p_auto_exit) else $error("auto input did not end test operation");

    property p_compare;
        @(posedge clk) disable iff (!rst_n)
        (graph || mode_q == RLSO_MEASURE) |=> (act_q == $past(exc));
    endproperty
    a_compare: assert property (p_compare) else $error("output level does not follow comparison");

    property p_polarity;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> (limit_switch_outputs[2] == (act_q[2] ~^ $past(cfg_q[2].pol_high)));
    endproperty
    a_polarity: assert property (p_polarity) else $error("switch output polarity wrong");

    property p_fixed_plc;
        @(posedge clk) disable iff (!rst_n)
        (plc_out[0] == limit_switch_outputs[0]) && (plc_out[1] == limit_switch_outputs[1]);
    endproperty
    a_fixed_plc: assert property (p_fixed_plc) else $error("fixed PLC positions not driven");

    property p_ref_gate;
        @(posedge clk) disable iff (!rst_n)
        (reg_we && cfg_hit && !thr_wr && !gref_ok) |=> !cfg_q[$past(cfg_idx)].ref_trig;
    endproperty
    a_ref_gate: assert property (p_ref_gate) else $error("trigger reference accepted without Y trigger");

    property p_trig_capture;
        @(posedge clk) disable iff (!rst_n)
        (active && y_trigger) |=> (xref_q == $past(meas_x));
    endproperty
    a_trig_capture: assert property (p_trig_capture) else $error("X position not captured at trigger");

    property p_ring_full;
        @(posedge clk) disable iff (!rst_n)
        (curve_push && !wr_prog && curve_cnt == RLSO_SLOT_W'(RLSO_CURVE_DEPTH))
        |=> (curve_cnt == RLSO_SLOT_W'(RLSO_CURVE_DEPTH)) ##1 1'b1;
    endproperty
    a_ring_full: assert property (p_ring_full) else $error("curve count moved past ten");

    property p_ring_grow;
        @(posedge clk) disable iff (!rst_n)
        (curve_push && !wr_prog && curve_cnt < RLSO_SLOT_W'(RLSO_CURVE_DEPTH))
        |=> (curve_cnt == $past(curve_cnt) + 1'b1) && status_q[RLSO_EV_CURVE];
    endproperty
    a_ring_grow: assert property (p_ring_grow) else $error("stored curve not counted");

endmodule

/* sim/rlso_plc_master.sv */
// PLC master model: latches the PLC output positions once per clock, as a
// controller polling its input card would. Assumes plc_out is synchronous to clk.
`timescale 1ns/1ps
module rlso_plc_master (
    input logic clk,
    input logic rst_n,
    input logic [7:0] plc_out,
    output logic [7:0] plc_seen
);
    // ==========================================================
    // Polling
    // One cycle of delay, like a real input scan; the bench allows for it
    logic [7:0] seen_d;
    always_comb begin
        seen_d = rst_n ? plc_out : 8'h00;
    end
    always_ff @(posedge clk) begin
        plc_seen <= seen_d;
    end
endmodule

/* sim/testbench.sv */
// Self-checking bench for the limit switch output block.
// Assumes the register port of the design and a PLC master model on plc_out.
`timescale 1ns/1ps
module testbench import rlso_pkg::*;;
    logic clk, rst_n, sample_valid, y_trigger, curve_end, in_auto, reg_we, reg_re, irq;
    logic [15:0] meas_x, meas_y;
    logic [7:0] reg_addr, plc_out, plc_seen;
    logic [31:0] reg_wdata, reg_rdata, rd_val;
    logic [5:0] lso;
    logic [1:0] op_mode;
    int err_count, comparisons, cycles;

    rlso_top u_rlso_top (.clk(clk), .rst_n(rst_n), .meas_x(meas_x), .meas_y(meas_y),
        .sample_valid(sample_valid), .y_trigger(y_trigger), .curve_end(curve_end), .in_auto(in_auto),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .limit_switch_outputs(lso), .plc_out(plc_out), .op_mode(op_mode), .irq(irq));
    rlso_plc_master u_rlso_plc_master (.clk(clk), .rst_n(rst_n), .plc_out(plc_out), .plc_seen(plc_seen));

    // ==========================================================
    // Clock and run limit
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Whole sequence needs under two hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 3000) begin
            err_count++;
            stop_test;
        end
    end

    // ==========================================================
    // Helpers
    task automatic stop_test;
        if (err_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic settle;
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        @(negedge clk);
        rd_val = reg_rdata;
        chk(rd_val, exp);
    endtask
    // Outputs are registered: one edge after the sample change
    task automatic setm(input logic [15:0] x, input logic [15:0] y);
        @(posedge clk);
        meas_x <= x;
        meas_y <= y;
        settle;
    endtask
    task automatic push_curve(input logic [15:0] k);
        @(posedge clk);
        meas_x <= k;
        meas_y <= k;
        sample_valid <= 1'b1;
        @(posedge clk);
        sample_valid <= 1'b0;
        curve_end <= 1'b1;
        @(posedge clk);
        curve_end <= 1'b0;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {rst_n, sample_valid, y_trigger, curve_end, in_auto, reg_we, reg_re} = 7'h00;
        {meas_x, meas_y, reg_addr, reg_wdata} = 72'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        settle;
        chk(lso, 6'h3F);
        chk(op_mode, 2'h0);
        settle;
        chk(plc_seen, 8'h3F);
        rdc(ADDR_MAP, 32'h0000_0B1A);
        rdc(8'h3C, 32'h0000_0000);
        for (int n = 0; n < RLSO_NOUT; n++) begin
            wr(ADDR_CFG_BASE + 8'(8 * n),
               (n == 1) ? 32'h0000_0001 : ((n == 2) ? 32'h0000_0006 : 32'h0000_0002));
            wr(ADDR_CFG_BASE + 8'(8 * n + 4), (n == 1) ? 32'h0000_0032 : 32'h0000_0064);
        end
        rdc(ADDR_CFG_BASE + 8'h10, 32'h0000_0002);
        rdc(ADDR_CFG_BASE + 8'h0C, 32'h0000_0032);
        wr(ADDR_MODE, 32'h0000_0001);
        setm(16'h0064, 16'h0000);
        chk(lso, 6'h02);
        setm(16'h0065, 16'h0000);
        chk(lso, 6'h3F);
        setm(16'h0065, 16'h0033);
        chk(lso, 6'h3D);
        settle;
        chk(plc_seen, 8'h3D);
        rdc(ADDR_LEVEL, 32'h0000_003F);
        // Trigger referencing once a Y trigger reference is selected
        wr(ADDR_GREF, 32'h0000_0001);
        wr(ADDR_CFG_BASE + 8'h10, 32'h0000_0006);
        rdc(ADDR_CFG_BASE + 8'h10, 32'h0000_0006);
        @(posedge clk);
        meas_x <= 16'h03E8;
        y_trigger <= 1'b1;
        @(posedge clk);
        y_trigger <= 1'b0;
        setm(16'h041A, 16'h0033);
        chk(lso, 6'h39);
        // Route outputs three to six to positions 7, 6, 5, 4; the model adds one cycle
        wr(ADDR_MAP, 32'h0000_0977);
        settle;
        settle;
        chk(plc_seen, 8'h71);
        setm(16'h044D, 16'h0033);
        chk(lso, 6'h3D);
        // Interrupt: sticky status, mask, write-one-to-clear
        wr(ADDR_STATUS, 32'h0000_00FF);
        rdc(ADDR_STATUS, 32'h0000_0000);
        wr(ADDR_MASK, 32'h0000_0004);
        setm(16'h03E8, 16'h0033);
        setm(16'h044D, 16'h0033);
        settle;
        chk(irq, 1'b1);
        wr(ADDR_MASK, 32'h0000_0000);
        settle;
        chk(irq, 1'b0);
        wr(ADDR_MASK, 32'h0000_0004);
        settle;
        chk(irq, 1'b1);
        wr(ADDR_STATUS, 32'h0000_0004);
        settle;
        chk(irq, 1'b0);
        // Graphical test: eleven curves, only the newest ten kept
        wr(ADDR_MODE, 32'h0000_0002);
        settle;
        chk(op_mode, 2'h2);
        for (int k = 1; k <= 11; k++) begin
            push_curve(16'(k));
        end
        settle;
        rdc(ADDR_CCOUNT, 32'h0000_000A);
        wr(ADDR_SLOT, 32'h0000_0000);
        rdc(ADDR_CURVE, 32'h0002_0002);
        wr(ADDR_SLOT, 32'h0000_0009);
        rdc(ADDR_CURVE, 32'h000B_000B);
        // History is kept per program: another program starts empty
        wr(ADDR_PROG, 32'h0000_0001);
        rdc(ADDR_PROG, 32'h0000_0001);
        rdc(ADDR_CCOUNT, 32'h0000_0000);
        rdc(ADDR_CURVE, 32'h0000_0000);
        wr(ADDR_PROG, 32'h0000_0000);
        rdc(ADDR_CCOUNT, 32'h0000_000A);
        setm(16'h0065, 16'h0000);
        chk(lso, 6'h3B);
        @(posedge clk);
        in_auto <= 1'b1;
        @(posedge clk);
        in_auto <= 1'b0;
        settle;
        chk(op_mode, 2'h1);
        // Outputs 1, 4, 5 and 6 rose in test operation, so their event bits are set too
        rdc(ADDR_STATUS, 32'h0000_00F9);
        wr(ADDR_MODE, 32'h0000_0003);
        rdc(ADDR_MODE, 32'h0000_0001);
        wr(ADDR_MODE, 32'h0000_0000);
        settle;
        chk(lso, 6'h02);
        stop_test;
    end
endmodule
